// file: verilog/boot_page_write_guard.sv
// Boot page write guard: protect bits, unlock key sequence and the gate
// between the flash programming controller and the flash array.
// Assumes one 40 MHz clock; the request comes from logic on that clock.
//
// Implementation choices: the Wishbone register port and the address map.
`include "boot_guard_defines.svh"
`default_nettype none

// Functional notes
// - Page 4 bit set blocks writes to 0x1FC30000..0x1FC33FFF.
// - Page 3 bit set blocks writes to 0x1FC2C000..0x1FC2FFFF.
// - Page 2 bit set blocks writes to 0x1FC28000..0x1FC2BFFF.
// - Page 1 bit set blocks writes to 0x1FC24000..0x1FC27FFF.
// - Page 0 bit set blocks writes to 0x1FC20000..0x1FC23FFF.
// - Protect register accepts writes only after the unlock key sequence.
// - Bits change only when unlocked and the upper lock bit is set.
module boot_page_write_guard
  import boot_guard_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Request from the flash programming controller
  input  wire flash_req_t  i_req,
  // Request passed on to the flash array, and refusal pulse
  output flash_req_t       o_req,
  output logic             o_req_blocked
);
  logic [4:0]  upper_boot_page_protect;
  logic [1:0]  boot_protect_lock;
  key_state_t  key_state;
  logic [4:0]  page_hit;
  logic        wb_req;
  logic        wr_prot;
  logic        wr_key;
  logic        block_hit;
  logic [2:0]  prot_ignored;
  logic [31:0] next_rdata;

  assign wb_req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_prot = wb_req && i_wb_we && (i_wb_adr == `PROT_OFS)
                && i_wb_sel[0];
  assign wr_key  = wb_req && i_wb_we && (i_wb_adr == `KEY_OFS)
                && (i_wb_sel == 4'hF);

  // One-cycle ack for every access, mapped or not.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
    end
  end

  // The key window closes on any bus write other than the expected next
  // step, so an interleaved access cannot reuse a half-done sequence.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      key_state <= KEY_IDLE;
    end else if (i_ce && wb_req && i_wb_we) begin
      case (key_state)
        KEY_IDLE: begin
          if (wr_key && i_wb_dat == `UNLOCK_KEY1) begin
            key_state <= KEY_HALF;
          end
        end
        KEY_HALF: begin
          if (wr_key && i_wb_dat == `UNLOCK_KEY2) begin
            key_state <= KEY_OPEN;
          end else begin
            key_state <= KEY_IDLE;
          end
        end
        KEY_OPEN: begin
          key_state <= KEY_IDLE;
        end
        default: begin
          key_state <= KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_protect_lock <= `LOCK_RESET;
    end else if (i_ce && wb_req && i_wb_we && i_wb_sel[0]
                 && i_wb_adr == `LOCK_OFS) begin
      boot_protect_lock <= i_wb_dat[1:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      upper_boot_page_protect <= `PROT_RESET;
    end else if (i_ce && wr_prot && key_state == KEY_OPEN
                 && boot_protect_lock[`LOCK_UPPER_BIT]) begin
      upper_boot_page_protect <= i_wb_dat[4:0];
    end
    // A write failing either condition leaves every bit as it was.
  end

  // Counts protect writes that were refused, saturating.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prot_ignored <= 3'h0;
    end else if (i_ce && wr_prot && !(key_state == KEY_OPEN
                 && boot_protect_lock[`LOCK_UPPER_BIT])
                 && prot_ignored != 3'h7) begin
      prot_ignored <= prot_ignored + 3'h1;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_wb_adr)
      `PROT_OFS: next_rdata[4:0] = upper_boot_page_protect;
      `LOCK_OFS: next_rdata[1:0] = boot_protect_lock;
      `STAT_OFS: begin
        next_rdata[1:0] = key_state;
        next_rdata[6:4] = prot_ignored;
      end
      default:   next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce && wb_req) begin
      o_wb_dat <= i_wb_we ? 32'h0000_0000 : next_rdata;
    end
  end

  page_decode u_page_decode (
    .i_addr     (i_req.addr),
    .o_page_hit (page_hit)
  );

  // One page per protect bit: bit n guards page n.
  assign block_hit = |(page_hit & upper_boot_page_protect);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_req         <= '0;
      o_req_blocked <= 1'b0;
    end else if (i_ce) begin
      o_req.addr    <= i_req.addr;
      o_req.erase   <= i_req.erase;
      o_req.valid   <= i_req.valid && !block_hit;
      o_req_blocked <= i_req.valid && block_hit;
    end
  end

  property p_blocked;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_ce && i_req.valid && block_hit) |=> !o_req.valid && o_req_blocked;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Write to protected page passed");

  property p_pass;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_ce && i_req.valid && !block_hit) |=> o_req.valid && !o_req_blocked;
  endproperty
  a_pass: assert property (p_pass)
    else $error("Permitted write dropped");

  property p_no_change_locked;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      !boot_protect_lock[`LOCK_UPPER_BIT]
        |=> $stable(upper_boot_page_protect);
  endproperty
  a_no_change_locked: assert property (p_no_change_locked)
    else $error("Protect bits changed without lock bit");

  property p_key_needed;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (key_state != KEY_OPEN) |=> $stable(upper_boot_page_protect);
  endproperty
  a_key_needed: assert property (p_key_needed)
    else $error("Protect bits changed without unlock");

  property p_ignored_count;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_ce && wr_prot && !(key_state == KEY_OPEN
       && boot_protect_lock[`LOCK_UPPER_BIT]) && prot_ignored != 3'h7)
        |=> prot_ignored == $past(prot_ignored) + 3'h1
            && $stable(upper_boot_page_protect);
  endproperty
  a_ignored_count: assert property (p_ignored_count)
    else $error("Refused protect write not ignored");

  property p_prot_taken;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_ce && wr_prot && key_state == KEY_OPEN
       && boot_protect_lock[`LOCK_UPPER_BIT])
        |=> upper_boot_page_protect == $past(i_wb_dat[4:0]);
  endproperty
  a_prot_taken: assert property (p_prot_taken)
    else $error("Permitted protect write not taken");

  // The window must close after one write, or a stray write could land.
  property p_open_consumed;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_ce && wb_req && i_wb_we && key_state == KEY_OPEN)
        |=> key_state == KEY_IDLE;
  endproperty
  a_open_consumed: assert property (p_open_consumed)
    else $error("Unlock window outlived the next write");

  property p_frozen;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_ce |=> $stable(o_req) && $stable(o_req_blocked)
                && $stable(upper_boot_page_protect);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("State moved while clock enable was low");

  property p_ack_once;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("Ack held longer than one cycle");
endmodule
`default_nettype wire

// file: verilog/boot_guard_defines.svh
// Offsets, field positions, reset values and address limits of the guard.
// Assumes a 32-bit Wishbone bus with byte addresses and word registers.
`ifndef BOOT_GUARD_DEFINES_SVH
`define BOOT_GUARD_DEFINES_SVH

`define PROT_OFS        8'h00
`define KEY_OFS         8'h04
`define LOCK_OFS        8'h08
`define STAT_OFS        8'h0C
`define PROT_RESET      5'h00
`define LOCK_RESET      2'h0
`define LOCK_LOWER_BIT  0
`define LOCK_UPPER_BIT  1
`define UNLOCK_KEY1     32'hAA99_6655
`define UNLOCK_KEY2     32'h5566_99AA
`define UPPER_PAGE_BASE 32'h1FC2_0000
`define UPPER_PAGE_LAST 32'h1FC3_3FFF
`define PAGE_SHIFT      14
`define PAGE_COUNT      5

`endif

// file: verilog/boot_guard_pkg.sv
// Types shared by the boot page write guard.
// Assumes the defines header is compiled with it.
`default_nettype none
package boot_guard_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_OPEN
  } key_state_t;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [31:0] addr;
  } flash_req_t;
endpackage
`default_nettype wire

// file: verilog/page_decode.sv
// Decodes a flash write address to the upper boot page it falls in.
// Assumes a physical byte address; pages are 16 KB each.
`include "boot_guard_defines.svh"
`default_nettype none
module page_decode (
  // Address in
  input  wire logic [31:0] i_addr,
  // One-hot page hit out
  output logic      [4:0]  o_page_hit
);
  logic        in_region;
  logic [31:0] offset;
  assign in_region = (i_addr >= `UPPER_PAGE_BASE)
                  && (i_addr <= `UPPER_PAGE_LAST);
  assign offset    = i_addr - `UPPER_PAGE_BASE;
  genvar g;
  generate
    for (g = 0; g < `PAGE_COUNT; g++) begin : g_page
      assign o_page_hit[g] = in_region
        && (offset[31:`PAGE_SHIFT] == 18'(g));
    end
  endgenerate
endmodule
`default_nettype wire

// file: bench/flash_ctrl_model.sv
// Flash programming controller model: issues one request per bench command.
// Assumes the bench raises i_go for one cycle, just after a rising edge.
`default_nettype none
module flash_ctrl_model
  import boot_guard_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // Command from the bench
  input  wire logic        i_go,
  input  wire logic        i_erase,
  input  wire logic [31:0] i_addr,
  // Request towards the guard
  output var flash_req_t   o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Between requests valid is cleared and the erase and address fields are inverted, so that a stale request can
  // never pass for a fresh one.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_req <= '0;
    end else if (i_go) begin
      o_req <= {1'b1, i_erase, i_addr};
    end else begin
      o_req <= {1'b0, ~o_req.erase, ~o_req.addr};
    end
  end
endmodule
`default_nettype wire

// file: bench/boot_page_write_guard_tb_top.sv
// Bench for the boot page write guard: registers over Wishbone, requests
// from the controller model. Assumes the design files and defines header.
`include "boot_guard_defines.svh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module boot_page_write_guard_tb_top
  import boot_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0]  p;
    logic [31:0] a;
    logic        b;
  } row_t;
  logic        clk, rst_n, cyc, stb, we, go, er, ack, blk, ce;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q, fa;
  flash_req_t  req_in, req_out;
  int          miscompares, n_tests, cycles;
  row_t        rows [12] = '{
    '{5'h10, 32'h1FC3_0000, 1'b1}, '{5'h10, 32'h1FC3_3FFF, 1'b1},
    '{5'h10, 32'h1FC2_FFFF, 1'b0}, '{5'h08, 32'h1FC2_C000, 1'b1},
    '{5'h08, 32'h1FC3_0000, 1'b0}, '{5'h04, 32'h1FC2_8000, 1'b1},
    '{5'h04, 32'h1FC2_BFFF, 1'b1}, '{5'h02, 32'h1FC2_4000, 1'b1},
    '{5'h01, 32'h1FC2_3FFF, 1'b1}, '{5'h01, 32'h1FC2_4000, 1'b0},
    '{5'h1F, 32'h1FC1_FFFF, 1'b0}, '{5'h1F, 32'h1FC3_4000, 1'b0}};

  boot_page_write_guard boot_page_write_guard_inst (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_req(req_in),
    .o_req(req_out), .o_req_blocked(blk));
  flash_ctrl_model flash_ctrl_model_inst (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_erase(er),
    .i_addr(fa), .o_req(req_in));

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic keyed(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, `KEY_OFS, `UNLOCK_KEY1);
    wb(1'b1, `KEY_OFS, `UNLOCK_KEY2);
    wb(1'b1, a, d);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    {rst_n, cyc, stb, we, go, er, adr, wdat, fa} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `PROT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    keyed(`PROT_OFS, 32'h0000_001F);
    wb(1'b0, `PROT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    keyed(`LOCK_OFS, 32'h0000_0002);
    wb(1'b1, `PROT_OFS, 32'h0000_001F);
    wb(1'b0, `PROT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wb(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(q[6:0], 7'h20)
    wb(1'b1, `KEY_OFS, `UNLOCK_KEY1);
    wb(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(q[6:0], 7'h21)
    wb(1'b1, `STAT_OFS, 32'h0000_0000);
    wb(1'b1, `KEY_OFS, `UNLOCK_KEY2);
    wb(1'b1, `PROT_OFS, 32'h0000_001F);
    wb(1'b0, `PROT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    foreach (rows[i]) begin
      keyed(`PROT_OFS, {27'h0, rows[i].p});
      wb(1'b0, `PROT_OFS, 32'h0000_0000);
      `CHK(q, {27'h0, rows[i].p})
      @(posedge clk);
      {go, fa, er} <= {1'b1, rows[i].a, i[0]};
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(req_out.valid, ~rows[i].b)
      `CHK(blk, rows[i].b)
      `CHK({req_out.erase, req_out.addr}, {i[0], rows[i].a})
    end
    // With the clock enable low a blocked request must leave no trace.
    @(posedge clk);
    {ce, go, fa, er} <= {1'b0, 1'b1, 32'h1FC3_0000, 1'b0};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(blk, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `PROT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    final_report();
  end
endmodule
`default_nettype wire
